// *** oia_chk.sv ***
// oia_chk: port assertions for oia_top
// assumes it is bound into each oia_top and sees only its ports
`timescale 1ns/1ps
module oia_chk
  import oia_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SETTLE_CYCLES
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // parameter write and read
  input wire logic        PRM_WR,
  input wire logic [7:0]  PRM_REC,
  input wire logic [3:0]  PRM_IDX,
  input wire logic [7:0]  PRM_DATA,
  input wire logic [7:0]  FILTER_BYTE,
  input wire logic        SETTLING,
  input wire logic        RD_EN,
  input wire logic [9:0]  RD_ADDR,
  input wire logic [15:0] RD_DATA,
  input wire logic        RD_ACK,
  // digital inputs and interrupts
  input wire logic [15:0] DI_PIN,
  input wire logic [15:0] IRQ_RISE_EN,
  input wire logic [15:0] IRQ_FALL_EN,
  input wire logic [15:0] IRQ_PEND,
  input wire logic        HW_IRQ,
  input wire logic [15:0] LOST_MAP,
  input wire logic        DIAG_IRQ,
  input wire logic [3:0]  CNT_A,
  input wire logic [3:0]  CNT_B,
  input wire logic        GATE_THREE,
  input wire logic        LATCH_THREE
);
  localparam int D = SETTLE_CYC;
  logic [7:0]  wr_q;
  logic [15:0] p_q [3];
  wire  logic  prm_take = PRM_WR && PRM_REC == PRM_RECORD_FILT && PRM_IDX == PRM_BYTE_FILT;
  wire  logic [15:0] pv = p_q[2];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  always_ff @(posedge CLK) begin
    if (prm_take) begin
      wr_q <= PRM_DATA;
    end
  end
  // pins as seen three edges earlier
  always_ff @(posedge CLK) begin
    p_q <= '{DI_PIN, p_q[0], p_q[1]};
  end
  rd_ack_a: assert property (RD_EN |=> RD_ACK)
    else $error("read not acknowledged");
  settle_on_a: assert property (prm_take |=> SETTLING)
    else $error("write did not start settling");
  settle_val_a: assert property (RD_EN && SETTLING && RD_ADDR == ADDR_AI_CH0
    |=> RD_DATA == PRM_ERR_VALUE) else $error("settling value wrong");
  filt_upd_a: assert property (prm_take |-> ##[1:D] FILTER_BYTE == wr_q)
    else $error("filter byte not applied in time");
  settle_len_a: assert property ($rose(SETTLING) |-> ##[1:D] !SETTLING)
    else $error("settling too long");
  hw_irq_a: assert property (HW_IRQ == (IRQ_PEND != 16'h0000))
    else $error("interrupt line differs from pending");
  no_irq_a: assert property ((IRQ_PEND & ~$past(IRQ_PEND) & ~$past(IRQ_RISE_EN)
    & ~$past(IRQ_FALL_EN)) == 16'h0000) else $error("pending without enable");
  lost_a: assert property ((LOST_MAP & ~$past(LOST_MAP) & ~$past(IRQ_PEND)) == 16'h0000)
    else $error("loss flagged while not pending");
  diag_a: assert property (DIAG_IRQ == (LOST_MAP != 16'h0000))
    else $error("diagnostics without loss");
  route_a: assert property ({LATCH_THREE, GATE_THREE, CNT_B, CNT_A} == {pv[15], pv[11],
    pv[10], pv[7], pv[4], pv[1], pv[9], pv[6], pv[3], pv[0]}) else $error("routing wrong");
  cover property ($rose(HW_IRQ));
  cover property ($rose(DIAG_IRQ));
  cover property ($fell(SETTLING));
endmodule
bind oia_top oia_chk #(.SETTLE_CYC(SETTLE_CYC)) oia_chk_i (.*);

// *** oia_filter.sv ***
// oia_filter: first-order smoothing filter for one analog channel
// assumes samples arrive with a one-cycle strobe on the core clock
`timescale 1ns/1ps
module oia_filter
  import oia_pkg::*;
#(
  parameter int unsigned W  = 16,
  parameter int unsigned SH = SHIFT_MAX
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         restart,
  input  wire logic [3:0]   shift,
  // sample stream
  input  wire logic         valid,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic signed [W+SH-1:0] acc_q;
  logic                   primed_q;
  logic signed [W+SH-1:0] x_ext;
  logic signed [W+SH:0]   diff;
  logic signed [W+SH:0]   diff_sh;
  logic signed [W+SH-1:0] step;

  assign x_ext   = $signed({din, {SH{1'b0}}});
  // a guard bit keeps the gap between two extreme samples from wrapping
  assign diff    = {x_ext[W+SH-1], x_ext} - {acc_q[W+SH-1], acc_q};
  assign diff_sh = diff >>> shift;
  assign step    = diff_sh[W+SH-1:0];

  // first sample after a restart loads directly so the output settles at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q    <= '0;
      primed_q <= 1'b0;
    end else if (restart) begin
      // the old value stands until the first sample under the new setting
      primed_q <= 1'b0;
    end else if (valid) begin
      primed_q <= 1'b1;
      if (!primed_q) begin
        acc_q <= x_ext;
      end else begin
        acc_q <= acc_q + step;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dout <= '0;
    end else begin
      dout <= acc_q[W+SH-1:SH];
    end
  end

endmodule

// *** oia_pkg.sv ***
// oia_pkg: constants shared by the onboard input acquisition block
// assumes a 40 MHz core clock and a 16-bit process image word
package oia_pkg;

  // clock rate and the settle time after a runtime parameter write
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned SETTLE_TIME_MS  = 2;
  // longest time, rounded down to whole cycles
  localparam int unsigned SETTLE_CYCLES   = (SETTLE_TIME_MS * CLK_HZ) / 1000;

  // process image input addresses
  localparam logic [9:0] ADDR_AI_CH0      = 10'h320;  // 800
  localparam logic [9:0] ADDR_AI_CH1      = 10'h322;  // 802
  localparam logic [9:0] ADDR_DI_LO       = 10'h088;  // 136
  localparam logic [9:0] ADDR_DI_HI       = 10'h089;  // 137

  // parameter record layout
  localparam logic [7:0] PRM_RECORD_FILT  = 8'h01;
  localparam logic [3:0] PRM_BYTE_RSVD    = 4'h0;
  localparam logic [3:0] PRM_BYTE_FILT    = 4'h1;
  localparam logic [7:0] PRM_RSVD_RESET   = 8'h00;
  localparam logic [7:0] PRM_FILT_RESET   = 8'h10;
  localparam int unsigned FILT_CH0_LSB    = 0;
  localparam int unsigned FILT_CH1_LSB    = 2;
  localparam int unsigned FILT_FIELD_W    = 2;

  // filter codes
  typedef enum logic [1:0] {
    OIA_FILT_2MS    = 2'b00,
    OIA_FILT_100MS  = 2'b01,
    OIA_FILT_1000MS = 2'b10,
    OIA_FILT_BAD    = 2'b11
  } oia_filt_e;

  // smoothing shift per filter setting
  localparam logic [3:0] SHIFT_NONE       = 4'h0;
  localparam logic [3:0] SHIFT_SMALL      = 4'h4;
  localparam logic [3:0] SHIFT_MEDIUM     = 4'h8;
  localparam int unsigned SHIFT_MAX       = 8;

  // fixed output values
  localparam logic [19:0] SETTLE_VALUE    = 20'h7FFFF;
  localparam logic [15:0] PRM_ERR_VALUE   = 16'h7FFF;
  localparam logic [15:0] WORD_POS_MAX    = 16'h7FFF;

  // digital input count and shared-function routing
  localparam int unsigned DI_COUNT        = 16;
  localparam int unsigned CNT_COUNT       = 4;
  localparam int unsigned GATE3_BIT       = 11;
  localparam int unsigned LATCH3_BIT      = 15;

endpackage

// *** oia_sensor.sv ***
// oia_sensor: field sensors and switches on the input terminals
// assumes fire and levels are driven on the rising edge of clk
`timescale 1ns/1ps
module oia_sensor (
  // commands
  input  wire logic        clk,
  input  wire logic        fire,
  input  wire logic [15:0] lvl0,
  input  wire logic [15:0] lvl1,
  input  wire logic [15:0] di,
  // converter and terminals
  output logic             valid,
  output logic      [15:0] a0,
  output logic      [15:0] a1,
  output logic      [15:0] pin
);
  initial begin
    valid = 1'b0;
    a0 = 16'h0000;
    a1 = 16'h0000;
    pin = 16'h0000;
  end
  // converter word is stale outside the strobe, so it keeps changing
  always @(posedge clk) begin
    valid <= fire;
    a0 <= fire ? lvl0 : ~a0;
    a1 <= fire ? lvl1 : ~a1;
  end
  // switches settle at an arbitrary moment inside the cycle
  always @(di) begin
    pin <= #(1 + $urandom_range(18, 0)) di;
  end
endmodule

// *** oia_top.sv ***
// oia_top: onboard analog and digital input acquisition with edge interrupts
// assumes converter samples and parameter writes on CLK; digital pins are asynchronous
//
// Contract
// RULE1 - analog channels at input words 800, 802
// RULE2 - three filter settings per analog channel
// RULE3 - without setting, channels use 1000ms filter
// RULE4 - filter byte bits 1:0 select channel 0
// RULE5 - bits 3:2 channel 1, default 10h
// RULE6 - runtime record 1 write applied, no restart
// RULE7 - new filter effective within 2ms
// RULE8 - settling outputs fixed value 7FFFFh; code outputs the word maximum 7FFFh
// RULE9 - invalid parameter outputs 7FFFh on channel
// RULE10 - digital inputs at bytes 136 and 137
// RULE11 - shared inputs handle 100kHz, others 1kHz
// RULE12 - per-input rising and falling interrupt enables
// RULE13 - no interrupt until an edge selected
// RULE14 - diagnostics interrupt only for lost interrupt
// RULE15 - rising 0-1, falling 1-0 on sampled input
// RULE16 - counter, gate and latch input routing
// RULE17 - edge while pending flags interrupt lost; code does not flag it when the input is acknowledged in the same cycle
`timescale 1ns/1ps
module oia_top
  import oia_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SETTLE_CYCLES,
  parameter logic [3:0]  SH_SMALL   = SHIFT_SMALL,
  parameter logic [3:0]  SH_MEDIUM  = SHIFT_MEDIUM
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // analog converter samples
  input  wire logic        AIN_VALID,
  input  wire logic [15:0] AIN0_DATA,
  input  wire logic [15:0] AIN1_DATA,
  // parameter record write
  input  wire logic        PRM_WR,
  input  wire logic [7:0]  PRM_REC,
  input  wire logic [3:0]  PRM_IDX,
  input  wire logic [7:0]  PRM_DATA,
  output logic      [7:0]  FILTER_BYTE,
  output logic             SETTLING,
  // process image read
  input  wire logic        RD_EN,
  input  wire logic [9:0]  RD_ADDR,
  output logic      [15:0] RD_DATA,
  output logic             RD_ACK,
  output logic             RD_ERR,
  // digital input pins
  input  wire logic [15:0] DI_PIN,
  // interrupt configuration and service
  input  wire logic [15:0] IRQ_RISE_EN,
  input  wire logic [15:0] IRQ_FALL_EN,
  input  wire logic [15:0] IRQ_ACK,
  input  wire logic        DIAG_ACK,
  output logic      [15:0] IRQ_PEND,
  output logic             HW_IRQ,
  output logic      [15:0] LOST_MAP,
  output logic             DIAG_IRQ,
  // shared-function inputs for counters
  output logic      [3:0]  CNT_A,
  output logic      [3:0]  CNT_B,
  output logic             GATE_THREE,
  output logic             LATCH_THREE
);

  // idle: setting in effect; settle: counting after a write, outputs fixed;
  // apply: one cycle that hands over the byte and restarts both filters
  typedef enum logic [1:0] {
    OIA_IDLE   = 2'b00,
    OIA_SETTLE = 2'b01,
    OIA_APPLY  = 2'b11
  } oia_state_e;

  // apply and return to idle follow the last count, so the whole sequence
  // from the taking edge fits in SETTLE_CYC cycles
  localparam logic [16:0] SETTLE_LAST = 17'(SETTLE_CYC - 2);

  // saturate a wide value into a positive signed word
  function automatic logic [15:0] sat_word(input logic [19:0] v);
    if (v > {4'h0, WORD_POS_MAX}) begin
      sat_word = WORD_POS_MAX;
    end else begin
      sat_word = v[15:0];
    end
  endfunction

  // smoothing shift for a filter code
  function automatic logic [3:0] code_shift(input logic [1:0] code);
    unique case (code)
      OIA_FILT_2MS:    code_shift = SHIFT_NONE;
      OIA_FILT_100MS:  code_shift = SH_SMALL;
      OIA_FILT_1000MS: code_shift = SH_MEDIUM;
      default:         code_shift = SHIFT_NONE;
    endcase
  endfunction

  // parameter record and apply sequence
  oia_state_e  state_q;
  logic [16:0] settle_cnt_q;
  logic [7:0]  filt_byte_q;
  logic [7:0]  pend_byte_q;
  logic        given_q;
  logic [1:0]  code_ch_q [2];
  logic        filt_wr;
  logic        restart;
  logic        apply_now;

  assign filt_wr = PRM_WR && (PRM_REC == PRM_RECORD_FILT)
                   && (PRM_IDX == PRM_BYTE_FILT);                // [RULE6]
  assign restart = (state_q == OIA_APPLY);
  // last counting cycle with no fresh write: the pending byte takes effect
  assign apply_now = (state_q == OIA_SETTLE) && !filt_wr
                     && (settle_cnt_q >= SETTLE_LAST);

  // accepted byte is kept as written, reserved bits included
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_byte_q <= PRM_FILT_RESET;                             // [RULE5]
    end else if (filt_wr) begin
      pend_byte_q <= PRM_DATA;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q      <= OIA_IDLE;
      settle_cnt_q <= '0;
    end else begin
      unique case (state_q)
        OIA_IDLE: begin
          if (filt_wr) begin
            state_q      <= OIA_SETTLE;
            settle_cnt_q <= '0;
          end
        end
        OIA_SETTLE: begin
          // a fresh write restarts the wait
          if (filt_wr) begin
            settle_cnt_q <= '0;
          end else if (settle_cnt_q >= SETTLE_LAST) begin
            state_q <= OIA_APPLY;                                // [RULE7]
          end else begin
            settle_cnt_q <= settle_cnt_q + 17'h00001;
          end
        end
        OIA_APPLY: begin
          settle_cnt_q <= '0;
          if (filt_wr) begin
            state_q <= OIA_SETTLE;
          end else begin
            state_q <= OIA_IDLE;
          end
        end
        default: begin
          state_q      <= OIA_IDLE;
          settle_cnt_q <= '0;
        end
      endcase
    end
  end

  // the byte resets to 10h, whose fields read 2ms; the channels keep the
  // medium filter until a written byte has been applied
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      filt_byte_q <= PRM_FILT_RESET;                             // [RULE5]
    end else if (apply_now) begin
      filt_byte_q <= pend_byte_q;                                // [RULE6] [RULE7]
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      given_q <= 1'b0;
    end else if (apply_now) begin
      given_q <= 1'b1;
    end
  end

  // codes in effect; medium filter until a setting has been given
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      code_ch_q[0] <= OIA_FILT_1000MS;                           // [RULE3]
      code_ch_q[1] <= OIA_FILT_1000MS;                           // [RULE3]
    end else if (given_q) begin
      code_ch_q[0] <= filt_byte_q[FILT_CH0_LSB +: FILT_FIELD_W]; // [RULE4]
      code_ch_q[1] <= filt_byte_q[FILT_CH1_LSB +: FILT_FIELD_W]; // [RULE5]
    end
  end

  assign FILTER_BYTE = filt_byte_q;
  assign SETTLING    = (state_q != OIA_IDLE);

  // analog channels
  logic [15:0] ain  [2];
  logic [15:0] filt [2];
  logic [15:0] aword [2];
  logic [3:0]  shift_ch [2];

  assign ain[0] = AIN0_DATA;
  assign ain[1] = AIN1_DATA;

  // both channels share the converter strobe and the restart of an apply
  for (genvar c = 0; c < 2; c++) begin : g_ach
    assign shift_ch[c] = code_shift(code_ch_q[c]);               // [RULE2]

    oia_filter #(
      .W  (16),
      .SH (SHIFT_MAX)
    ) u_filter (
      .clk     (CLK),
      .rst_n   (RESET_N),
      .restart (restart),
      .shift   (shift_ch[c]),
      .valid   (AIN_VALID),
      .din     (ain[c]),
      .dout    (filt[c])
    );

    always_comb begin
      if (SETTLING) begin
        // 7FFFFh is wider than the word, so the word maximum stands in
        aword[c] = sat_word(SETTLE_VALUE);                       // [RULE8]
      end else if (code_ch_q[c] == OIA_FILT_BAD) begin
        // code 11b is no legal setting and counts as a parameter error
        aword[c] = PRM_ERR_VALUE;                                // [RULE9]
      end else begin
        aword[c] = filt[c];
      end
    end
  end

  // digital input synchroniser; at 40 MHz the 100kHz inputs are well oversampled
  // fast and slow inputs share this path, so both rates are covered
  logic [15:0] di_meta_q;
  logic [15:0] di_sync_q;
  logic [15:0] di_prev_q;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      di_meta_q <= '0;
      di_sync_q <= '0;
    end else begin
      di_meta_q <= DI_PIN;                                       // [RULE11]
      di_sync_q <= di_meta_q;
    end
  end

  // starts low: no edge in the first cycle, but a pin held high through
  // reset shows one rising edge once it is synchronised
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      di_prev_q <= '0;
    end else begin
      di_prev_q <= di_sync_q;
    end
  end

  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] evt;
  logic [15:0] lost;

  assign rise = di_sync_q & ~di_prev_q;                          // [RULE15]
  assign fall = ~di_sync_q & di_prev_q;                          // [RULE15]
  assign evt  = (rise & IRQ_RISE_EN) | (fall & IRQ_FALL_EN);     // [RULE12] [RULE13]
  // an acknowledge in the same cycle frees the slot, so that edge is not lost
  assign lost = evt & IRQ_PEND & ~IRQ_ACK;                       // [RULE17]

  // a new edge wins over the acknowledge of the same input
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_PEND <= '0;                                            // [RULE13]
    end else begin
      IRQ_PEND <= (IRQ_PEND & ~IRQ_ACK) | evt;                   // [RULE12]
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LOST_MAP <= '0;
    end else if (DIAG_ACK) begin
      LOST_MAP <= lost;
    end else begin
      LOST_MAP <= LOST_MAP | lost;                               // [RULE17]
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DIAG_IRQ <= 1'b0;
    end else begin
      DIAG_IRQ <= (DIAG_IRQ & ~DIAG_ACK) | (|lost);              // [RULE14]
    end
  end

  assign HW_IRQ = |IRQ_PEND;

  // shared-function routing from the synchronised inputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CNT_A       <= '0;
      CNT_B       <= '0;
      GATE_THREE  <= 1'b0;
      LATCH_THREE <= 1'b0;
    end else begin
      // counter k takes its A and B inputs from pins 3k and 3k+1
      for (int k = 0; k < CNT_COUNT; k++) begin
        CNT_A[k] <= di_sync_q[3*k];                              // [RULE16]
        CNT_B[k] <= di_sync_q[3*k+1];                            // [RULE16]
      end
      GATE_THREE  <= di_sync_q[GATE3_BIT];                       // [RULE16]
      LATCH_THREE <= di_sync_q[LATCH3_BIT];                      // [RULE16]
    end
  end

  // process image read: one cycle to answer
  // unmapped addresses answer zero with the error flag; data holds between reads
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= '0;
      RD_ACK  <= 1'b0;
      RD_ERR  <= 1'b0;
    end else begin
      RD_ACK <= RD_EN;
      RD_ERR <= 1'b0;
      if (RD_EN) begin
        unique case (RD_ADDR)
          ADDR_AI_CH0: RD_DATA <= aword[0];                      // [RULE1]
          ADDR_AI_CH1: RD_DATA <= aword[1];                      // [RULE1]
          ADDR_DI_LO:  RD_DATA <= {8'h00, di_sync_q[7:0]};       // [RULE10]
          ADDR_DI_HI:  RD_DATA <= {8'h00, di_sync_q[15:8]};      // [RULE10]
          default: begin
            RD_DATA <= '0;
            RD_ERR  <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// *** tb_top.sv ***
// tb_top: self-checking bench for oia_top
// assumes oia_sensor stands in for the field wiring
`timescale 1ns/1ps
module tb_top
  import oia_pkg::*;
;
  localparam int S = 20;
  logic CLK = 0, RESET_N = 0, PRM_WR = 0, DIAG_ACK = 0, RD_EN = 0, fire = 0;
  logic [7:0]  PRM_REC = 0, PRM_DATA = 0, b;
  logic [3:0]  PRM_IDX = 0;
  logic [9:0]  RD_ADDR = 0;
  logic [15:0] IRQ_RISE_EN = 0, IRQ_FALL_EN = 0, IRQ_ACK = 0, lv0 = 0, lv1 = 0, di = 0;
  logic [15:0] a, e, r;
  logic [3:0]  lo [4] = '{4'h4, 4'h9, 4'h2, 4'hF};
  wire         AIN_VALID, SETTLING, RD_ACK, RD_ERR, HW_IRQ, DIAG_IRQ, GATE_THREE, LATCH_THREE;
  wire  [15:0] AIN0_DATA, AIN1_DATA, DI_PIN, RD_DATA, IRQ_PEND, LOST_MAP;
  wire  [7:0]  FILTER_BYTE;
  wire  [3:0]  CNT_A, CNT_B;
  logic [16:0] exp_q [$];
  int          mismatches = 0, comparisons = 0;
  always #12.5 CLK = ~CLK;
  oia_top #(.SETTLE_CYC(S)) oia_top_i (.*);
  oia_sensor oia_sensor_i (.clk(CLK), .fire(fire), .lvl0(lv0), .lvl1(lv1), .di(di),
    .valid(AIN_VALID), .a0(AIN0_DATA), .a1(AIN1_DATA), .pin(DI_PIN));
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic rd(input logic [9:0] ad, input logic [16:0] want);
    exp_q.push_back(want);
    RD_EN <= 1'b1;
    RD_ADDR <= ad;
    @(posedge CLK);
    RD_EN <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] rec, input logic [3:0] idx, input logic [7:0] d);
    PRM_WR <= 1'b1;
    PRM_REC <= rec;
    PRM_IDX <= idx;
    PRM_DATA <= d;
    @(posedge CLK);
    PRM_WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic smp(input logic [15:0] x);
    lv0 <= x;
    lv1 <= x;
    fire <= 1'b1;
    @(posedge CLK);
    fire <= 1'b0;
    cyc(4);
  endtask
  task automatic pins(input logic [15:0] v);
    di <= v;
    cyc(6);
  endtask
  function automatic logic [15:0] fx(input logic [1:0] c, input logic [15:0] x);
    case (c)
      2'b00: return x + 16'h1000;
      2'b01: return x + (16'h1000 >> SHIFT_SMALL);
      2'b10: return x + (16'h1000 >> SHIFT_MEDIUM);
      default: return PRM_ERR_VALUE;
    endcase
  endfunction
  always @(negedge CLK) begin
    if (RD_ACK === 1'b1) begin
      check({RD_ERR, RD_DATA}, exp_q.pop_front());
    end
  end
  initial begin
    #(5000 * 25);
    mismatches++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hE566));
    cyc(4);
    RESET_N <= 1'b1;
    cyc(1);
    check(FILTER_BYTE, PRM_FILT_RESET);
    check({SETTLING, IRQ_PEND}, 17'h00000);
    smp(16'h0000);
    smp(16'h4000);
    rd(ADDR_AI_CH0, 17'h00040);
    rd(ADDR_AI_CH1, 17'h00040);
    rd(10'h321, 17'h10000);
    for (int i = 0; i < 4; i++) begin
      b = {4'($urandom), lo[i]};
      wr(PRM_RECORD_FILT, PRM_BYTE_FILT, b);
      rd(ADDR_AI_CH0, 17'h07FFF);
      cyc(S + 2);
      check(FILTER_BYTE, b);
      check(SETTLING, 1'b0);
      a = 16'($urandom_range(4095, 0));
      smp(a);
      smp(a + 16'h1000);
      rd(ADDR_AI_CH0, {1'b0, fx(b[1:0], a)});
      rd(ADDR_AI_CH1, {1'b0, fx(b[3:2], a)});
    end
    // other records and bytes leave the setting alone
    wr(8'h02, PRM_BYTE_FILT, 8'h00);
    wr(PRM_RECORD_FILT, PRM_BYTE_RSVD, 8'h00);
    check({SETTLING, FILTER_BYTE}, {1'b0, b});
    r = 16'($urandom);
    pins(r);
    rd(ADDR_DI_LO, {9'h000, r[7:0]});
    rd(ADDR_DI_HI, {9'h000, r[15:8]});
    e = 16'({r[15], r[11], r[10], r[7], r[4], r[1], r[9], r[6], r[3], r[0]});
    check({LATCH_THREE, GATE_THREE, CNT_B, CNT_A}, e);
    check(IRQ_PEND, 16'h0000);
    pins(16'h0000);
    IRQ_RISE_EN <= 16'h0008;
    IRQ_FALL_EN <= 16'h0020;
    pins(16'h0038);
    check({HW_IRQ, IRQ_PEND}, 17'h10008);
    pins(16'h0018);
    check({DIAG_IRQ, IRQ_PEND}, 17'h00028);
    pins(16'h0010);
    pins(16'h0018);
    check({DIAG_IRQ, LOST_MAP}, 17'h10008);
    IRQ_ACK <= 16'hFFFF;
    DIAG_ACK <= 1'b1;
    cyc(1);
    IRQ_ACK <= 16'h0000;
    DIAG_ACK <= 1'b0;
    cyc(2);
    check({HW_IRQ, IRQ_PEND}, 17'h00000);
    check({DIAG_IRQ, LOST_MAP}, 17'h00000);
    cyc(2);
    end_sim();
  end
endmodule
